// ---- include/tal_pkg.sv ----
// tal_pkg: register map, field positions, reset values and timing counts
// for the thermal alarm output block; used by logic/ files by scoped name.
package tal_pkg;

	// register byte addresses on the axi4-lite slave
	localparam logic [7:0] ADDR_CONFIG     = 8'h04;  // control word
	localparam logic [7:0] ADDR_UPPER      = 8'h08;  // upper limit
	localparam logic [7:0] ADDR_LOWER      = 8'h0C;  // lower limit
	localparam logic [7:0] ADDR_CRIT       = 8'h10;  // critical_alarm_limit
	localparam logic [7:0] ADDR_AMBIENT    = 8'h14;  // newest reading + flags
	localparam logic [7:0] ADDR_CAPABILITY = 8'h18;  // read-only capability
	localparam logic [7:0] ADDR_RESOLUTION = 8'h20;  // pointer 0000_1000 * 4
	localparam logic [7:0] RES_POINTER     = 8'h08;  // printed pointer (index)

	// control word field positions
	localparam int CFG_MODE      = 0;   // 1 = interrupt mode
	localparam int CFG_POL       = 1;   // 1 = active high
	localparam int CFG_CRIT_ONLY = 2;
	localparam int CFG_EN        = 3;
	localparam int CFG_STATUS    = 4;
	localparam int CFG_CLEAR     = 5;
	localparam int CFG_LOCK_W    = 6;
	localparam int CFG_LOCK_C    = 7;
	localparam int CFG_SHDN      = 8;
	localparam int CFG_HYST_LO   = 9;
	localparam int CFG_HYST_HI   = 10;
	localparam int CAP_RES_LO    = 3;   // resolution mirror in capability
	localparam int CAP_RES_HI    = 4;

	// reset values
	localparam logic [15:0] CONFIG_RST = 16'h0000;
	localparam logic [1:0]  RES_RST    = 2'b01;   // 0.25 degree per lsb
	localparam logic [12:0] LIMIT_RST  = 13'h0000;

	// hysteresis in 1/16 degree units: 0, 1.5, 3, 6 degrees
	localparam logic [12:0] HYST_0 = 13'h0000;
	localparam logic [12:0] HYST_1 = 13'h0018;
	localparam logic [12:0] HYST_2 = 13'h0030;
	localparam logic [12:0] HYST_3 = 13'h0060;

	// conversion_time per resolution, in ms, and clock rate
	localparam int CLK_HZ       = 40_000_000;
	localparam int CONV_MS_0    = 30;
	localparam int CONV_MS_1    = 65;
	localparam int CONV_MS_2    = 130;
	localparam int CONV_MS_3    = 260;
	localparam int CONV_CYC_0   = CONV_MS_0 * (CLK_HZ / 1000);
	localparam int CONV_CYC_1   = CONV_MS_1 * (CLK_HZ / 1000);
	localparam int CONV_CYC_2   = CONV_MS_2 * (CLK_HZ / 1000);
	localparam int CONV_CYC_3   = CONV_MS_3 * (CLK_HZ / 1000);

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- logic/tal_alarm_top.sv ----
// tal_alarm_top: limit comparison and alarm pin logic with axi4-lite registers.
// assumes ambient readings arrive as 13-bit two's complement in 1/16 degree
// on ambient_temp, sampled at each completed conversion; one clock domain.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module tal_alarm_top #(
	parameter int CONV_CYC_0 = tal_pkg::CONV_CYC_0,
	parameter int CONV_CYC_1 = tal_pkg::CONV_CYC_1,
	parameter int CONV_CYC_2 = tal_pkg::CONV_CYC_2,
	parameter int CONV_CYC_3 = tal_pkg::CONV_CYC_3
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// sensor
	input  wire logic [12:0] ambient_temp,
	output logic             conv_done,
	// alarm pin
	output logic             alarm_out
);

	// register state
	logic [15:0] config_word;   // stored control bits (status/clear not stored)
	logic [12:0] upper_limit;
	logic [12:0] lower_limit;
	logic [12:0] critical_alarm_limit;
	logic [1:0]  resolution;
	logic [12:0] ambient;       // newest reading

	// comparison state, the three comparisons each with a hysteresis band
	logic        above_upper;
	logic        below_lower;
	logic        above_crit;
	logic        int_latch;     // interrupt-mode event held until cleared
	logic        alarm_active;  // logical alarm before polarity

	// bus handshake state
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// decoded control bits
	wire         mode_int   = config_word[tal_pkg::CFG_MODE];
	wire         pol_high   = config_word[tal_pkg::CFG_POL];
	wire         crit_only  = config_word[tal_pkg::CFG_CRIT_ONLY];
	wire         alarm_en   = config_word[tal_pkg::CFG_EN];
	wire         locked     = config_word[tal_pkg::CFG_LOCK_W]
	                          | config_word[tal_pkg::CFG_LOCK_C];
	wire         shutdown   = config_word[tal_pkg::CFG_SHDN];
	wire [1:0]   hyst_sel   = config_word[tal_pkg::CFG_HYST_HI:tal_pkg::CFG_HYST_LO];

	// hysteresis value
	logic [12:0] hyst;
	always_comb begin
		case (hyst_sel)
			2'b00:   hyst = tal_pkg::HYST_0;
			2'b01:   hyst = tal_pkg::HYST_1;
			2'b10:   hyst = tal_pkg::HYST_2;
			default: hyst = tal_pkg::HYST_3;
		endcase
	end

	// conversion pacing; stopped in shutdown
	tal_conv_timer #(
		.CYC_0 (CONV_CYC_0),
		.CYC_1 (CONV_CYC_1),
		.CYC_2 (CONV_CYC_2),
		.CYC_3 (CONV_CYC_3)
	) u_timer (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.run        (!shutdown),
		.resolution (resolution),
		.conv_done  (conv_done)
	);

	// signed compare helpers on the new reading
	wire signed [12:0] t_new  = $signed(ambient_temp);
	wire signed [12:0] t_up   = $signed(upper_limit);
	wire signed [12:0] t_lo   = $signed(lower_limit);
	wire signed [12:0] t_cr   = $signed(critical_alarm_limit);
	wire signed [12:0] t_hy   = $signed(hyst);

	// upper trips above the plain limit and crit at it, both release only below limit minus hysteresis; lower trips below limit minus hysteresis, releases at limit
	wire next_above_upper = (t_new > t_up) ? 1'b1 :
	                        (t_new < t_up - t_hy) ? 1'b0 : above_upper;
	wire next_above_crit  = (t_new >= t_cr) ? 1'b1 :
	                        (t_new < t_cr - t_hy) ? 1'b0 : above_crit;
	wire next_below_lower = (t_new < t_lo - t_hy) ? 1'b1 :
	                        (t_new >= t_lo) ? 1'b0 : below_lower;
	wire next_window      = next_above_upper | next_below_lower;
	wire cur_window       = above_upper | below_lower;

	// write decode
	wire         wr_fire    = aw_held & w_held & !s_axi_bvalid;
	wire         wr_cfg     = wr_fire & (aw_addr == tal_pkg::ADDR_CONFIG);
	wire         wr_up      = wr_fire & (aw_addr == tal_pkg::ADDR_UPPER);
	wire         wr_lo      = wr_fire & (aw_addr == tal_pkg::ADDR_LOWER);
	wire         wr_cr      = wr_fire & (aw_addr == tal_pkg::ADDR_CRIT);
	wire         wr_res     = wr_fire & (aw_addr == tal_pkg::ADDR_RESOLUTION);
	wire         wr_hit     = wr_cfg | wr_up | wr_lo | wr_cr | wr_res;
	wire         int_clear  = wr_cfg & w_strb[0] & w_data[tal_pkg::CFG_CLEAR];
	wire         limit_ok   = !locked;
	wire [15:0]  cfg_wdata  = w_data[15:0];

	// next control word: byte lanes, lock on hysteresis, shutdown set blocked
	logic [15:0] next_config;
	always_comb begin
		next_config = config_word;
		if (wr_cfg && w_strb[0]) begin
			next_config[7:0] = cfg_wdata[7:0];
		end
		if (wr_cfg && w_strb[1]) begin
			next_config[tal_pkg::CFG_SHDN] = cfg_wdata[tal_pkg::CFG_SHDN]
			                                 & (!locked | shutdown);
			if (!locked) begin
				next_config[tal_pkg::CFG_HYST_HI:tal_pkg::CFG_HYST_LO] =
					cfg_wdata[tal_pkg::CFG_HYST_HI:tal_pkg::CFG_HYST_LO];
			end
		end
		// lock bits stay once set; status and clear never stored
		next_config[tal_pkg::CFG_LOCK_W] = config_word[tal_pkg::CFG_LOCK_W]
		                                   | next_config[tal_pkg::CFG_LOCK_W];
		next_config[tal_pkg::CFG_LOCK_C] = config_word[tal_pkg::CFG_LOCK_C]
		                                   | next_config[tal_pkg::CFG_LOCK_C];
		next_config[tal_pkg::CFG_STATUS] = 1'b0;
		next_config[tal_pkg::CFG_CLEAR]  = 1'b0;
		next_config[15:11]               = 5'h00;
	end

	// register writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			config_word          <= tal_pkg::CONFIG_RST;
			upper_limit          <= tal_pkg::LIMIT_RST;
			lower_limit          <= tal_pkg::LIMIT_RST;
			critical_alarm_limit <= tal_pkg::LIMIT_RST;
			resolution           <= tal_pkg::RES_RST;
		end else begin
			config_word <= next_config;
			if (wr_up && limit_ok && w_strb[0]) begin
				upper_limit <= w_data[12:0];
			end
			if (wr_lo && limit_ok && w_strb[0]) begin
				lower_limit <= w_data[12:0];
			end
			if (wr_cr && limit_ok && w_strb[0]) begin
				critical_alarm_limit <= w_data[12:0];
			end
			if (wr_res && w_strb[0]) begin
				resolution <= w_data[1:0];
			end
		end
	end

	// comparisons update only on a completed conversion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ambient     <= 13'h0000;
			above_upper <= 1'b0;
			below_lower <= 1'b0;
			above_crit  <= 1'b0;
		end else if (conv_done) begin
			ambient     <= ambient_temp;
			above_upper <= next_above_upper;
			below_lower <= next_below_lower;
			above_crit  <= next_above_crit;
		end
	end

	// interrupt latch: set on crossing into the window violation, or by a
	// critical event; a clear write, shutdown or a switch to comparator releases it; set wins over clear
	wire int_set = conv_done & !shutdown & mode_int & !crit_only
	               & ((next_window & !cur_window) | next_above_crit);
	// switch to comparator seen at the write edge, so the pin never glitches
	wire mode_to_cmp = mode_int & !next_config[tal_pkg::CFG_MODE];
	// a clear while still critical is void; software clears after release
	wire clear_ok    = int_clear & !above_crit;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_latch <= 1'b0;
		end else begin
			if (int_set) begin
				int_latch <= 1'b1;
			end else if (clear_ok || shutdown || mode_to_cmp) begin
				int_latch <= 1'b0;
			end
		end
	end

	// rearm: results are ignored until a conversion completes after
	// leaving shutdown or after a switch to comparator mode
	logic armed;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed <= 1'b0;
		end else if (shutdown || mode_to_cmp) begin
			armed <= 1'b0;
		end else if (conv_done) begin
			armed <= 1'b1;
		end
	end

	// logical alarm: critical forces comparator, crit-only looks at crit
	always_comb begin
		if (!alarm_en || shutdown || !armed) begin
			alarm_active = 1'b0;
		end else if (crit_only) begin
			alarm_active = above_crit;
		end else if (above_crit) begin
			alarm_active = 1'b1;
		end else if (mode_int) begin
			alarm_active = int_latch;
		end else begin
			alarm_active = cur_window;
		end
	end

	// pin level from flop; polarity applied
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// inactive level of the reset polarity
			alarm_out <= !tal_pkg::CONFIG_RST[tal_pkg::CFG_POL];
		end else begin
			alarm_out <= alarm_active ~^ pol_high;
		end
	end

	// axi write channel: accept address and data in either order
	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= tal_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? tal_pkg::RESP_OKAY : tal_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
			end
		end
	end

	// read mux; status bit shows the logical alarm before polarity, never one in shutdown
	wire        status_bit = alarm_active & !shutdown;
	wire [7:0]  rd_addr    = {s_axi_araddr[7:2], 2'b00};
	wire [15:0] cfg_read   = {config_word[15:5], status_bit, config_word[3:0]};
	wire [15:0] cap_read   = {11'h000, resolution, 3'b000};
	wire [15:0] amb_read   = {above_crit, above_upper, below_lower, ambient};
	logic [31:0] rd_value;
	logic        rd_hit;
	always_comb begin
		rd_hit   = 1'b1;
		rd_value = 32'h0000_0000;
		case (rd_addr)
			tal_pkg::ADDR_CONFIG:     rd_value = {16'h0000, cfg_read};
			tal_pkg::ADDR_UPPER:      rd_value = {19'h0_0000, upper_limit};
			tal_pkg::ADDR_LOWER:      rd_value = {19'h0_0000, lower_limit};
			tal_pkg::ADDR_CRIT:       rd_value = {19'h0_0000, critical_alarm_limit};
			tal_pkg::ADDR_AMBIENT:    rd_value = {16'h0000, amb_read};
			tal_pkg::ADDR_CAPABILITY: rd_value = {16'h0000, cap_read};
			tal_pkg::ADDR_RESOLUTION: rd_value = {30'h0000_0000, resolution};
			default:                  rd_hit   = 1'b0;
		endcase
	end

	// axi read channel: one beat after address accepted
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= tal_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_value;
			s_axi_rresp  <= rd_hit ? tal_pkg::RESP_OKAY : tal_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// ---- logic/tal_conv_timer.sv ----
// tal_conv_timer: paces conversions; a pulse marks each completed one.
// assumes a single clock, synchronous active-low reset and run as a level.
`timescale 1ns/100ps
module tal_conv_timer #(
	parameter int CYC_0 = tal_pkg::CONV_CYC_0,
	parameter int CYC_1 = tal_pkg::CONV_CYC_1,
	parameter int CYC_2 = tal_pkg::CONV_CYC_2,
	parameter int CYC_3 = tal_pkg::CONV_CYC_3
) (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// control
	input  wire logic       run,
	input  wire logic [1:0] resolution,
	// completion
	output logic            conv_done
);

	logic [31:0] count;      // cycles into the current conversion
	logic [31:0] period;     // length of conversion at this resolution
	wire         at_end;     // last cycle of a conversion

	// conversion_time follows the selected resolution
	always_comb begin
		case (resolution)
			2'b00:   period = 32'(CYC_0);
			2'b01:   period = 32'(CYC_1);
			2'b10:   period = 32'(CYC_2);
			default: period = 32'(CYC_3);
		endcase
	end

	assign at_end = (count + 32'h0000_0001 >= period);

	// restart from zero while stopped, so the first result after
	// leaving shutdown takes a whole conversion_time
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			count     <= 32'h0000_0000;
			conv_done <= 1'b0;
		end else if (at_end) begin
			count     <= 32'h0000_0000;
			conv_done <= 1'b1;
		end else begin
			count     <= count + 32'h0000_0001;
			conv_done <= 1'b0;
		end
	end

endmodule

// ---- tb/tal_alarm_checker.sv ----
// tal_alarm_checker: register bus and alarm timing assertions on the top ports.
// assumes a bind to tal_alarm_top; one clock, synchronous active-low reset.
`timescale 1ns/100ps
module tal_alarm_checker (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// sensor and alarm
	input wire logic        conv_done,
	input wire logic        alarm_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// answers stand until the master takes them
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rresp)) else $error("read answer dropped");
	// no new request taken while an answer is pending
	chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	// one cycle from read request to answer, two cycles for a write
	chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	// every register fits in the low sixteen bits
	chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	chk_conv_pulse: assert property (conv_done |=> !conv_done)
		else $error("conversion pulse too long");
	// the pin moves after a conversion decision or a register write only
	chk_alarm_cause: assert property ($changed(alarm_out)
		|-> $past(conv_done, 2) || s_axi_bvalid || $past(s_axi_bvalid))
		else $error("alarm moved without cause");
endmodule

// ---- tb/tal_sensor_model.sv ----
// tal_sensor_model: sensing front end that presents the requested reading.
// assumes temp_set from the bench; reading follows it one clock later.
`timescale 1ns/100ps
module tal_sensor_model (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// requested temperature, 1/16 degree
	input  wire logic [12:0] temp_set,
	// reading to the block
	output logic      [12:0] ambient_temp
);
	// front end tracks the die temperature each clock
	always_ff @(posedge aclk) begin
		ambient_temp <= aresetn ? temp_set : 13'h0000;
	end
endmodule

// ---- tb/tb_thermal_alarm_output_logic.sv ----
// tb_thermal_alarm_output_logic: register and alarm scenarios for tal_alarm_top.
// assumes a 40 MHz clock and shortened conversion counts of 20..80 cycles.
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_thermal_alarm_output_logic;
	localparam int CYC [4] = '{20, 40, 60, 80};  // shortened conversion counts
	logic        aclk, aresetn;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, conv_done, alarm_out;
	logic [12:0] ambient_temp, temp_set;
	int          failures, compares, cyc, n;

	tal_alarm_top #(.CONV_CYC_0(CYC[0]), .CONV_CYC_1(CYC[1]), .CONV_CYC_2(CYC[2]),
		.CONV_CYC_3(CYC[3])) u_tal_alarm_top (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .ambient_temp, .conv_done, .alarm_out);
	tal_sensor_model u_tal_sensor_model (.aclk, .aresetn, .temp_set, .ambient_temp);

	// 25 ns clock
	initial begin
		aclk = 0;
		forever #12.5 aclk = ~aclk;
	end

	// hang guard
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			stop_test();
		end
	end

	task stop_test;
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// one write, address and data offered together
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
		logic aw, w;
		aw = 0;
		w = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			aw = aw | (s_axi_awvalid & s_axi_awready);
			w = w | (s_axi_wvalid & s_axi_wready);
			if (aw) s_axi_awvalid <= 0;
			if (w) s_axi_wvalid <= 0;
		end while (!(aw && w));
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 0;
		`CHK(s_axi_bresp, er)
	endtask

	// one read
	task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'b00);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		while (!s_axi_rvalid) @(posedge aclk);
		s_axi_rready <= 0;
		d = s_axi_rdata;
		`CHK(s_axi_rresp, er)
	endtask

	task pulse;
		do @(posedge aclk); while (!conv_done);
	endtask

	// k conversions, then let the pin settle
	task conv(input int k);
		repeat (k) pulse();
		repeat (3) @(posedge aclk);
	endtask

	task cfg(input logic [31:0] d);
		wr(tal_pkg::ADDR_CONFIG, d);
		repeat (3) @(posedge aclk);
	endtask

	// new temperature, two conversions, expected pin level
	task tmp(input logic [12:0] t, input logic e);
		temp_set <= t;
		conv(2);
		`CHK(alarm_out, e)
	endtask

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, temp_set} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{failures, compares, cyc} = '0;
		s_axi_wstrb = 4'hF;
		aresetn = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		rd(tal_pkg::ADDR_RESOLUTION, rv);
		`CHK(rv, 32'h0000_0001)
		rd(tal_pkg::ADDR_CAPABILITY, rv);
		`CHK(rv[4:3], 2'b01)
		rd(8'h3C, rv, tal_pkg::RESP_SLVERR);
		wr(8'h3C, 32'h0000_0001, tal_pkg::RESP_SLVERR);
		// each resolution code and its conversion spacing
		for (int r = 0; r < 4; r++) begin
			wr(tal_pkg::ADDR_RESOLUTION, 32'(r));
			rd(tal_pkg::ADDR_CAPABILITY, rv);
			`CHK(rv[4:3], 2'(r))
			pulse();
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (!conv_done);
			`CHK(n, CYC[r])
		end
		wr(tal_pkg::ADDR_RESOLUTION, 32'h0000_0001);
		wr(tal_pkg::ADDR_UPPER, 32'h0000_01E0);
		wr(tal_pkg::ADDR_LOWER, 32'h0000_00A0);
		wr(tal_pkg::ADDR_CRIT, 32'h0000_0320);
		// comparator window, active high, then active low and alarm disabled
		cfg(32'h0000_000A);
		tmp(13'h0140, 0);
		tmp(13'h0230, 1);
		rd(tal_pkg::ADDR_CONFIG, rv);
		`CHK(rv[4], 1'b1)
		rd(tal_pkg::ADDR_AMBIENT, rv);
		`CHK(rv, 32'h0000_4230)
		tmp(13'h0060, 1);
		tmp(13'h0140, 0);
		cfg(32'h0000_0008);
		tmp(13'h0230, 0);
		tmp(13'h0140, 1);
		cfg(32'h0000_0002);
		tmp(13'h0230, 0);
		// every hysteresis step on a falling reading
		for (int h = 0; h < 4; h++) begin
			cfg(32'h0000_000A | (32'(h) << 9));
			tmp(13'h01E1, 1);
			tmp(13'h01E1 - ((h == 0) ? 13'h0000 : 13'(12 << h)), 1);
			tmp(13'h01DF - ((h == 0) ? 13'h0000 : 13'(12 << h)), 0);
		end
		// shutdown drops the pin and stops conversions
		cfg(32'h0000_000A);
		tmp(13'h0230, 1);
		cfg(32'h0000_010A);
		`CHK(alarm_out, 1'b0)
		rd(tal_pkg::ADDR_CONFIG, rv);
		`CHK(rv[4], 1'b0)
		n = 0;
		repeat (100) begin
			@(posedge aclk);
			n += conv_done;
		end
		`CHK(n, 0)
		cfg(32'h0000_000A);
		`CHK(alarm_out, 1'b0)
		conv(1);
		`CHK(alarm_out, 1'b1)
		// interrupt mode latch and clear
		tmp(13'h0140, 0);
		cfg(32'h0000_000B);
		tmp(13'h0230, 1);
		tmp(13'h0140, 1);
		cfg(32'h0000_002B);
		`CHK(alarm_out, 1'b0)
		tmp(13'h0230, 1);
		cfg(32'h0000_000A);
		`CHK(alarm_out, 1'b0)
		// critical event forces comparator behaviour
		tmp(13'h0140, 0);
		cfg(32'h0000_000B);
		tmp(13'h0370, 1);
		cfg(32'h0000_002B);
		`CHK(alarm_out, 1'b1)
		tmp(13'h0140, 1);
		cfg(32'h0000_002B);
		`CHK(alarm_out, 1'b0)
		// critical-only comparator
		cfg(32'h0000_000F);
		tmp(13'h0230, 0);
		tmp(13'h0370, 1);
		tmp(13'h0140, 0);
		// locks protect limits and hysteresis
		cfg(32'h0000_004A);
		wr(tal_pkg::ADDR_UPPER, 32'h0000_0100);
		rd(tal_pkg::ADDR_UPPER, rv);
		`CHK(rv, 32'h0000_01E0)
		cfg(32'h0000_064A);
		rd(tal_pkg::ADDR_CONFIG, rv);
		`CHK(rv[10:9], 2'b00)
		// reset mid-run: locks, resolution and pin return to defaults
		wr(tal_pkg::ADDR_RESOLUTION, 32'h0000_0003);
		aresetn <= 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		rd(tal_pkg::ADDR_RESOLUTION, rv);
		`CHK(rv, 32'h0000_0001)
		rd(tal_pkg::ADDR_CONFIG, rv);
		`CHK(rv, 32'h0000_0000)
		`CHK(alarm_out, 1'b1)
		stop_test();
	end
endmodule

bind tal_alarm_top tal_alarm_checker u_tal_alarm_checker (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .conv_done, .alarm_out);
